//--- shared/rmc_pkg.sv
// Register map, reset values and timing constants of the reference monitor config block
package rmc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_ISR_STATUS = 6'h02;
   localparam logic [5:0] IDX_MON_FAIL = 6'h07;
   localparam logic [5:0] IDX_FAIL_EN = 6'h08;
   localparam logic [5:0] IDX_SETUP = 6'h0a;
   localparam logic [5:0] IDX_DISQ_TIME = 6'h0b;
   localparam logic [5:0] IDX_QUAL_TIME = 6'h0c;
   localparam logic [5:0] IDX_FREEZE = 6'h0d;
   localparam logic [5:0] IDX_IRQ_CLEAR = 6'h0e;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0f;
   // Reset values
   localparam logic [7:0] RST_FAIL_EN = 8'h66;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_DISQ_TIME = 8'haa;
   localparam logic [7:0] RST_QUAL_TIME = 8'h55;
   localparam logic [7:0] RST_FREEZE = 8'h00;
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h01;
   // Field positions and codes
   localparam int FAIL_LOS_BIT = 0;
   localparam int FAIL_SCM_BIT = 1;
   localparam int FAIL_CFM_BIT = 2;
   localparam int FAIL_GST_BIT = 3;
   localparam int SETUP_DIV_BIT = 0;
   localparam int SETUP_DIFF_BIT = 4;
   localparam int ISR_REF_FAIL_BIT = 0;
   localparam logic [7:0] FREEZE_ON = 8'h01;
   localparam logic [7:0] FREEZE_OFF = 8'h00;
   // Timing: millisecond time base from the system clock
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_NS = 1_000_000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   localparam logic [14:0] DISQ_MIN_MS = 15'h0000;
   localparam logic [14:0] DISQ_10_MS = 15'd10;
   localparam logic [14:0] DISQ_50_MS = 15'd50;
   localparam logic [14:0] DISQ_2500_MS = 15'd2500;
   typedef enum logic [1:0] {
      GS_QUALIFIED = 2'b00,
      GS_SOAK_DISQ = 2'b01,
      GS_DISQUALIFIED = 2'b11,
      GS_SOAK_QUAL = 2'b10
   } rmc_gs_type;
endpackage

//--- core/rmc_guard_soak.sv
// Guard soak timer: disqualify and requalify the reference
`timescale 1ns/10ps
module rmc_guard_soak
   import rmc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic tick,
   input wire logic fail_in,
   input wire logic [1:0] disq_sel,
   input wire logic [1:0] qual_sel,
   output logic gst_fail
);
   rmc_gs_type state_ff, nxt_state;
   logic [14:0] cnt_ff, nxt_cnt;
   logic [14:0] disq_t, qual_t;
   logic [2:0] qual_mult;

   always_comb begin
      case (disq_sel) // R07
         2'b00: disq_t = DISQ_MIN_MS;
         2'b01: disq_t = DISQ_10_MS;
         2'b10: disq_t = DISQ_50_MS;
         default: disq_t = DISQ_2500_MS;
      endcase
      // Three bits so that code 11 does not wrap to zero
      qual_mult = {1'b0, qual_sel} + 3'd1;
      qual_t = 15'(disq_t * {qual_mult, 1'b0}); // R08
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         GS_QUALIFIED: begin
            nxt_cnt = '0;
            if (fail_in) begin
               nxt_state = GS_SOAK_DISQ;
            end
         end
         GS_SOAK_DISQ: begin
            if (!fail_in) begin
               nxt_state = GS_QUALIFIED;
            end else if (cnt_ff >= disq_t) begin // R07
               nxt_state = GS_DISQUALIFIED;
            end else if (tick) begin // R12
               nxt_cnt = cnt_ff + 15'd1;
            end
         end
         GS_DISQUALIFIED: begin
            nxt_cnt = '0;
            if (!fail_in) begin
               nxt_state = GS_SOAK_QUAL;
            end
         end
         GS_SOAK_QUAL: begin
            if (fail_in) begin
               nxt_state = GS_DISQUALIFIED;
            end else if (cnt_ff >= qual_t) begin // R08
               nxt_state = GS_QUALIFIED;
            end else if (tick) begin // R12
               nxt_cnt = cnt_ff + 15'd1;
            end
         end
         default: begin
            nxt_state = GS_QUALIFIED;
            nxt_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff <= GS_QUALIFIED;
         cnt_ff <= '0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   assign gst_fail = (state_ff == GS_DISQUALIFIED) || (state_ff == GS_SOAK_QUAL);

   ////////////////////////////////////////////////////////////////////////////
   min_disq_a: assert property ( // R07
      @(posedge sys_clk) disable iff (srst)
      (clk_en && state_ff == GS_QUALIFIED && fail_in && disq_sel == 2'b00)
      ##1 (clk_en && fail_in && disq_sel == 2'b00) |=> gst_fail)
      else $error("minimum disqualify delay not honoured");
   qual_wait_a: assert property ( // R08
      @(posedge sys_clk) disable iff (srst)
      (state_ff == GS_SOAK_QUAL && nxt_state == GS_QUALIFIED) |-> (cnt_ff >= qual_t && !fail_in))
      else $error("requalified before qualify time");
   qual_scale_a: assert property ( // R08
      @(posedge sys_clk) disable iff (srst)
      (qual_sel == 2'b11) |-> (qual_t == disq_t * 15'd8))
      else $error("qualify time not eight times disqualify time");
endmodule

//--- core/rmc_ref_monitor_cfg.sv
// Reference monitor configuration registers with APB access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// R01: Failure enable bits 3:0 govern signal loss, single cycle, coarse frequency and guard soak.
// R02: A zero enable bit masks that indicator, a one leaves it enabled.
// R03: Masking only affects the interrupt status; raw monitor failure bits always update. The code holds them while the freeze register is 0x01.
// R04: Pre-divider bit high halves the reference toward the DPLL, low passes it undivided.
// R05: With the pre-divider on, software programs frequency registers with half the frequency.
// R06: Setup bit 4 selects a differential reference when high, single-ended when low.
// R07: Disqualify code 00/01/10/11 gives minimum, 10 ms, 50 ms or 2.5 s delay.
// R08: Qualify code 00 to 11 gives two, four, six or eight times the disqualify time.
// R09: Writing 0x01 to the freeze register stops internal updates of latched status.
// R10: Writing 0x00 to the freeze register re-enables internal updates of latched status.
// R11: An enabled failure sets the sticky reference failure bit, which raises the interrupt.
// R12: Guard soak intervals are timed from a time base derived from the system clock.
////////////////////////////////////////////////////////////////////////////////
module rmc_ref_monitor_cfg
   import rmc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_p,
   input wire logic ref_n,
   input wire logic los_in,
   input wire logic scm_in,
   input wire logic cfm_in,
   output logic ref_to_dpll,
   output logic ref_diff_sel,
   output logic ref_disqualified,
   output logic irq
);
   // Register index decode, valid only for aligned in-range addresses
   function automatic logic idx_hit(input logic [11:0] addr, input logic [5:0] idx);
      idx_hit = (addr == {4'h0, idx, 2'b00});
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [4:0] sync1_ff, sync2_ff;
   logic ref_prev_ff, div_ff, ref_out_ff;
   logic nxt_ref_prev, nxt_div, nxt_ref_out;
   logic ref_sel, ref_rise;
   logic [17:0] tick_cnt_ff, nxt_tick_cnt;
   logic tick;
   logic [3:0] raw_fail;
   logic gst_fail;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else if (clk_en) begin
         sync1_ff <= {cfm_in, scm_in, los_in, ref_n, ref_p};
         sync2_ff <= sync1_ff;
      end
   end

   logic [7:0] setup_ff;
   always_comb begin
      ref_sel = setup_ff[SETUP_DIFF_BIT] ? (sync2_ff[0] & ~sync2_ff[1]) : sync2_ff[0]; // R06
      ref_rise = ref_sel & ~ref_prev_ff;
      nxt_ref_prev = ref_sel;
      nxt_div = div_ff ^ ref_rise;
      nxt_ref_out = setup_ff[SETUP_DIV_BIT] ? div_ff : ref_sel; // R04
      nxt_tick_cnt = (tick_cnt_ff == 18'(TICK_CYCLES - 1)) ? '0 : tick_cnt_ff + 18'd1; // R12
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ref_prev_ff <= 1'b0;
         div_ff <= 1'b0;
         ref_out_ff <= 1'b0;
         tick_cnt_ff <= '0;
      end else if (clk_en) begin
         ref_prev_ff <= nxt_ref_prev;
         div_ff <= nxt_div;
         ref_out_ff <= nxt_ref_out;
         tick_cnt_ff <= nxt_tick_cnt;
      end
   end

   assign tick = (tick_cnt_ff == 18'(TICK_CYCLES - 1));
   assign ref_to_dpll = ref_out_ff;
   assign ref_diff_sel = setup_ff[SETUP_DIFF_BIT]; // R06

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] disq_ff, qual_ff;

   rmc_guard_soak u_guard_soak (
      .sys_clk(sys_clk),
      .srst(srst),
      .clk_en(clk_en),
      .tick(tick),
      .fail_in(sync2_ff[3] | sync2_ff[4]),
      .disq_sel(disq_ff[1:0]),
      .qual_sel(qual_ff[1:0]),
      .gst_fail(gst_fail)
   );

   assign raw_fail = {gst_fail, sync2_ff[4], sync2_ff[3], sync2_ff[2]}; // R01
   assign ref_disqualified = gst_fail;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] fail_en_ff, freeze_ff, irq_en_ff;
   logic [3:0] mon_fail_ff;
   logic isr_ff;
   logic [7:0] nxt_fail_en, nxt_setup, nxt_disq, nxt_qual, nxt_freeze, nxt_irq_en;
   logic [3:0] nxt_mon_fail;
   logic nxt_isr;
   logic [31:0] prdata_ff, nxt_prdata;
   logic wr, mapped, locked, enabled_fail;

   assign pready = clk_en;
   assign wr = psel & penable & pwrite & pready;
   assign locked = (freeze_ff == FREEZE_ON);
   assign enabled_fail = |(raw_fail & fail_en_ff[3:0]); // R02

   always_comb begin
      mapped = idx_hit(paddr, IDX_ISR_STATUS) | idx_hit(paddr, IDX_MON_FAIL) |
               idx_hit(paddr, IDX_FAIL_EN) | idx_hit(paddr, IDX_SETUP) |
               idx_hit(paddr, IDX_DISQ_TIME) | idx_hit(paddr, IDX_QUAL_TIME) |
               idx_hit(paddr, IDX_FREEZE) | idx_hit(paddr, IDX_IRQ_CLEAR) |
               idx_hit(paddr, IDX_IRQ_ENABLE);
      nxt_fail_en = fail_en_ff;
      nxt_setup = setup_ff;
      nxt_disq = disq_ff;
      nxt_qual = qual_ff;
      nxt_freeze = freeze_ff;
      nxt_irq_en = irq_en_ff;
      nxt_mon_fail = mon_fail_ff;
      nxt_isr = isr_ff;
      if (wr && idx_hit(paddr, IDX_FAIL_EN)) begin
         nxt_fail_en = pwdata[7:0]; // R01
      end
      if (wr && idx_hit(paddr, IDX_SETUP)) begin
         nxt_setup = pwdata[7:0];
      end
      if (wr && idx_hit(paddr, IDX_DISQ_TIME)) begin
         nxt_disq = pwdata[7:0];
      end
      if (wr && idx_hit(paddr, IDX_QUAL_TIME)) begin
         nxt_qual = pwdata[7:0];
      end
      if (wr && idx_hit(paddr, IDX_FREEZE)) begin
         nxt_freeze = pwdata[7:0]; // R09 R10
      end
      if (wr && idx_hit(paddr, IDX_IRQ_ENABLE)) begin
         nxt_irq_en = pwdata[7:0];
      end
      // Software clears first, so a same-cycle set wins
      if (wr && idx_hit(paddr, IDX_MON_FAIL)) begin
         nxt_mon_fail = mon_fail_ff & ~pwdata[3:0];
      end
      if (wr && idx_hit(paddr, IDX_IRQ_CLEAR) && pwdata[ISR_REF_FAIL_BIT]) begin
         nxt_isr = 1'b0;
      end
      if (!locked) begin // R09 R10
         nxt_mon_fail = nxt_mon_fail | raw_fail; // R03
         if (enabled_fail) begin
            nxt_isr = 1'b1; // R11
         end
      end
      nxt_prdata = '0;
      if (idx_hit(paddr, IDX_ISR_STATUS)) begin
         nxt_prdata[ISR_REF_FAIL_BIT] = isr_ff;
      end else if (idx_hit(paddr, IDX_MON_FAIL)) begin
         nxt_prdata[3:0] = mon_fail_ff;
      end else if (idx_hit(paddr, IDX_FAIL_EN)) begin
         nxt_prdata[7:0] = fail_en_ff;
      end else if (idx_hit(paddr, IDX_SETUP)) begin
         nxt_prdata[7:0] = setup_ff;
      end else if (idx_hit(paddr, IDX_DISQ_TIME)) begin
         nxt_prdata[7:0] = disq_ff;
      end else if (idx_hit(paddr, IDX_QUAL_TIME)) begin
         nxt_prdata[7:0] = qual_ff;
      end else if (idx_hit(paddr, IDX_FREEZE)) begin
         nxt_prdata[7:0] = freeze_ff;
      end else if (idx_hit(paddr, IDX_IRQ_ENABLE)) begin
         nxt_prdata[7:0] = irq_en_ff;
      end
      if (!psel || pwrite) begin
         nxt_prdata = prdata_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fail_en_ff <= RST_FAIL_EN;
         setup_ff <= RST_SETUP;
         disq_ff <= RST_DISQ_TIME;
         qual_ff <= RST_QUAL_TIME;
         freeze_ff <= RST_FREEZE;
         irq_en_ff <= RST_IRQ_ENABLE;
         mon_fail_ff <= '0;
         isr_ff <= 1'b0;
         prdata_ff <= '0;
      end else if (clk_en) begin
         fail_en_ff <= nxt_fail_en;
         setup_ff <= nxt_setup;
         disq_ff <= nxt_disq;
         qual_ff <= nxt_qual;
         freeze_ff <= nxt_freeze;
         irq_en_ff <= nxt_irq_en;
         mon_fail_ff <= nxt_mon_fail;
         isr_ff <= nxt_isr;
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata = prdata_ff;
   assign pslverr = psel & penable & ~mapped;
   assign irq = isr_ff & irq_en_ff[ISR_REF_FAIL_BIT]; // R11

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   en_mask_a: assert property ( // R02
      (clk_en && !locked && enabled_fail) |=> isr_ff)
      else $error("enabled failure did not set status");
   masked_off_a: assert property ( // R02
      (clk_en && !isr_ff && !enabled_fail && !(wr && idx_hit(paddr, IDX_FREEZE))) |=> !isr_ff)
      else $error("masked failure set status");
   raw_latch_a: assert property ( // R03
      (clk_en && !locked && raw_fail[FAIL_LOS_BIT] && !fail_en_ff[FAIL_LOS_BIT]) |=> mon_fail_ff[FAIL_LOS_BIT])
      else $error("raw failure bit not latched");
   lock_hold_a: assert property ( // R09
      (clk_en && locked && !wr) |=> ($stable(mon_fail_ff) && $stable(isr_ff)))
      else $error("latched status changed while frozen");
   lock_write_a: assert property ( // R09
      (wr && idx_hit(paddr, IDX_FREEZE) && pwdata[7:0] == FREEZE_ON) |=> locked)
      else $error("freeze write did not lock");
   unlock_a: assert property ( // R10
      (wr && idx_hit(paddr, IDX_FREEZE) && pwdata[7:0] == FREEZE_OFF) |=> !locked)
      else $error("unfreeze write did not unlock");
   irq_raise_a: assert property ( // R11
      ($rose(isr_ff) && irq_en_ff[ISR_REF_FAIL_BIT]) |-> irq)
      else $error("status set without interrupt");
   pass_thru_a: assert property ( // R04
      (clk_en && !setup_ff[SETUP_DIV_BIT]) |=> (ref_to_dpll == $past(ref_sel)))
      else $error("undivided reference mismatch");
   divide_a: assert property ( // R04
      (clk_en && setup_ff[SETUP_DIV_BIT] && ref_rise) ##1 clk_en[*2] |=> (ref_to_dpll != $past(ref_to_dpll, 2)))
      else $error("divided reference did not toggle");
   diff_sel_a: assert property ( // R06
      (wr && idx_hit(paddr, IDX_SETUP)) |=> (ref_diff_sel == $past(pwdata[SETUP_DIFF_BIT])))
      else $error("input type select not applied");
endmodule

//--- tb/rmc_ref_source.sv
// Reference source model: clock pins and raw monitor levels
`timescale 1ns/10ps
module rmc_ref_source (
   input wire logic run,
   input wire logic diff,
   input wire logic [2:0] fail,
   output logic ref_p,
   output logic ref_n,
   output logic los_in,
   output logic scm_in,
   output logic cfm_in
);
   initial ref_p = 1'b0;
   // Stands still unless told to run, 40 ns period
   always #20 if (run) ref_p = ~ref_p;
   // Single-ended mode keeps the complement pin grounded
   assign ref_n = diff ? ~ref_p : 1'b0;
   assign los_in = fail[0];
   assign scm_in = fail[1];
   assign cfm_in = fail[2];
endmodule

//--- tb/reference_monitor_config_bench.sv
// Self-checking bench of the reference monitor config block
`timescale 1ns/10ps
module reference_monitor_config_bench;
   import rmc_pkg::*;
   localparam int T = 4;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic run = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [2:0] fail = 3'h0;
   logic [31:0] prdata, rd, rnd;
   logic pready, pslverr, err, prev;
   logic ref_p, ref_n, los_in, scm_in, cfm_in;
   logic ref_to_dpll, ref_diff_sel, ref_disqualified, irq;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 32'h9e7d_4830;
   int n;
   logic [5:0] rw_idx [4] = '{IDX_FAIL_EN, IDX_SETUP, IDX_DISQ_TIME, IDX_QUAL_TIME};
   // Qualify code per disqualify code; code 11 meets a nonzero disqualify time
   int qsel [4] = '{1, 3, 2, 0};

   always #2.5 sys_clk = ~sys_clk;

   rmc_ref_monitor_cfg #(.TICK_CYCLES(T)) dut (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_p(ref_p), .ref_n(ref_n),
      .los_in(los_in), .scm_in(scm_in), .cfm_in(cfm_in), .ref_to_dpll(ref_to_dpll),
      .ref_diff_sel(ref_diff_sel), .ref_disqualified(ref_disqualified), .irq(irq));

   rmc_ref_source src (.run(run), .diff(ref_diff_sel), .fail(fail), .ref_p(ref_p), .ref_n(ref_n),
      .los_in(los_in), .scm_in(scm_in), .cfm_in(cfm_in));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {4'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      check(rd, exp);
   endtask

   task automatic wait_dq(input logic v, output int c);
      c = 0;
      while (ref_disqualified !== v && c < 40000) begin
         @(posedge sys_clk);
         c++;
      end
   endtask

   task automatic clear_all();
      apb(1'b1, IDX_MON_FAIL, 32'h0000_000f);
      apb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0001);
   endtask

   function automatic int disq_cyc(int code);
      int ms [4] = '{0, 10, 50, 2500};
      return code == 0 ? 2 : ms[code] * T;
   endfunction

   function automatic logic near(int a, int b);
      return ((a > b) ? a - b : b - a) <= 2 * T + 8;
   endfunction

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         bad_count++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      rdchk(IDX_FAIL_EN, {24'h0, RST_FAIL_EN});
      rdchk(IDX_SETUP, {24'h0, RST_SETUP});
      rdchk(IDX_DISQ_TIME, {24'h0, RST_DISQ_TIME});
      rdchk(IDX_QUAL_TIME, {24'h0, RST_QUAL_TIME});
      rdchk(IDX_FREEZE, {24'h0, RST_FREEZE});
      rdchk(IDX_IRQ_ENABLE, {24'h0, RST_IRQ_ENABLE});
      apb(1'b1, IDX_ISR_STATUS, 32'h0000_00ff);
      rdchk(IDX_ISR_STATUS, 32'h0000_0000);
      apb(1'b0, 6'h3f, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      foreach (rw_idx[i]) begin
         rnd = $random(seed);
         apb(1'b1, rw_idx[i], rnd);
         rdchk(rw_idx[i], {24'h0, rnd[7:0]});
      end
      $display("test registers done");
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, IDX_SETUP, 32'(i << SETUP_DIFF_BIT));
         @(posedge sys_clk);
         check({31'h0, ref_diff_sel}, 32'(i));
      end
      run <= 1'b1;
      for (int d = 0; d < 2; d++) begin
         apb(1'b1, IDX_SETUP, 32'(d));
         n = 0;
         prev = ref_to_dpll;
         repeat (400) begin
            @(posedge sys_clk);
            n += (ref_to_dpll === 1'b1 && prev === 1'b0);
            prev = ref_to_dpll;
         end
         check({31'h0, near(n * 8, (50 >> d) * 8)}, 32'h1);
      end
      run <= 1'b0;
      $display("test reference path done");
      // Keep the guard soak from firing during short monitor pulses
      apb(1'b1, IDX_DISQ_TIME, {24'h0, RST_DISQ_TIME});
      for (int k = 0; k < 3; k++) begin
         for (int m = 0; m < 2; m++) begin
            apb(1'b1, IDX_FAIL_EN, 32'(m << k));
            fail <= 3'(1 << k);
            repeat (6) @(posedge sys_clk);
            fail <= 3'h0;
            repeat (6) @(posedge sys_clk);
            rdchk(IDX_MON_FAIL, 32'(1 << k));
            rdchk(IDX_ISR_STATUS, 32'(m));
            check({31'h0, irq}, 32'(m));
            clear_all();
            rdchk(IDX_MON_FAIL, 32'h0000_0000);
            check({31'h0, irq}, 32'h0000_0000);
         end
      end
      $display("test masking done");
      apb(1'b1, IDX_FAIL_EN, 32'h0000_0001);
      apb(1'b1, IDX_FREEZE, {24'h0, FREEZE_ON});
      fail <= 3'h1;
      repeat (6) @(posedge sys_clk);
      rdchk(IDX_MON_FAIL, 32'h0000_0000);
      rdchk(IDX_ISR_STATUS, 32'h0000_0000);
      apb(1'b1, IDX_FREEZE, {24'h0, FREEZE_OFF});
      repeat (6) @(posedge sys_clk);
      rdchk(IDX_MON_FAIL, 32'h0000_0001);
      rdchk(IDX_ISR_STATUS, 32'h0000_0001);
      fail <= 3'h0;
      repeat (6) @(posedge sys_clk);
      clear_all();
      $display("test freeze done");
      apb(1'b1, IDX_FAIL_EN, 32'h0000_0008);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, IDX_DISQ_TIME, 32'(k));
         apb(1'b1, IDX_QUAL_TIME, 32'(qsel[k]));
         fail <= 3'h2;
         wait_dq(1'b1, n);
         check({31'h0, near(n, disq_cyc(k))}, 32'h1);
         rdchk(IDX_MON_FAIL, 32'h0000_000a);
         rdchk(IDX_ISR_STATUS, 32'h0000_0001);
         fail <= 3'h0;
         wait_dq(1'b0, n);
         check({31'h0, near(n, disq_cyc(k) * 2 * (qsel[k] + 1))}, 32'h1);
         clear_all();
      end
      $display("test guard soak done");
      print_verdict();
   end
endmodule
